/* design/spg_link_shift.sv */
/*
 * Link-side shift engine, clocked by the master's serial clock.
 * Assumes frameIdle is high outside frames and that txByte stays
 * still while a byte is being shifted out.
 */
`timescale 1ns/1ps
`default_nettype none
module spg_link_shift (
	// Link
	input  wire logic       spiClk,
	input  wire logic       frameIdle,
	input  wire logic       rst,
	input  wire logic       mosi,
	output logic            miso,
	// Byte exchange with the system side
	input  wire logic [7:0] txByte,
	output logic      [7:0] rxByte,
	output logic            rxToggle
);
	logic [2:0] bitCnt_q;
	logic [6:0] shIn_q;
	logic [7:0] shOut_q;

	// ****************************************
	// Receive on rising edges
	// ****************************************
	always_ff @(posedge spiClk or posedge frameIdle) begin
		if (frameIdle) begin
			bitCnt_q <= 3'h0;
			shIn_q   <= 7'h00;
		end else begin
			bitCnt_q <= bitCnt_q + 3'h1;
			shIn_q   <= {shIn_q[5:0], mosi};
		end
	end

	// Held a whole byte, so the system side can sample it calmly
	always_ff @(posedge spiClk or posedge rst) begin
		if (rst) begin
			rxByte   <= 8'h00;
			rxToggle <= 1'b0;
		end else if (!frameIdle && bitCnt_q == 3'h7) begin
			rxByte   <= {shIn_q, mosi};
			rxToggle <= ~rxToggle;
		end
	end

	// ****************************************
	// Transmit on falling edges
	// ****************************************
	always_ff @(negedge spiClk or posedge frameIdle) begin
		if (frameIdle) begin
			shOut_q <= 8'h00;
		end else if (bitCnt_q == 3'h1) begin
			shOut_q <= {txByte[6:0], 1'b0};
		end else begin
			shOut_q <= {shOut_q[6:0], 1'b0};
		end
	end

	// First bit comes straight from the staged byte
	assign miso = (bitCnt_q == 3'h0) ? txByte[7] : shOut_q[7];

endmodule : spg_link_shift
`default_nettype wire

/* design/spg_pkg.sv */
/*
 * Shared constants of the serial slave port: register locations,
 * field positions, reset values, command layout and flash geometry.
 * Assumes a byte-wide processor register bus with separate special
 * function register and external data spaces.
 */
package spg_pkg;

	// ****************************************
	// Register locations
	// ****************************************
	localparam logic [15:0] SPG_FLASH_SECURITY_BIT_ADDR  = 16'h00B2;
	localparam logic [15:0] SPG_CMD_ADDR     = 16'h00FD;
	localparam logic [15:0] SPG_STAT_ADDR    = 16'h2708;
	localparam logic [15:0] SPG_CTRL_ADDR    = 16'h270C;

	// ****************************************
	// Field positions and reset values
	// ****************************************
	localparam int          SPG_FLASH_SECURITY_BIT_BIT   = 6;
	localparam int          SPG_ENABLE_BIT   = 4;
	localparam int          SPG_RESTRICT_BIT = 3;
	localparam logic        SPG_FLASH_SECURITY_BIT_RST   = 1'h0;
	localparam logic        SPG_ENABLE_RST   = 1'h1;
	localparam logic        SPG_RESTRICT_RST = 1'h0;
	localparam logic [7:0]  SPG_STAT_RST     = 8'h00;
	localparam logic [7:0]  SPG_CMD_RST      = 8'h00;
	localparam logic [2:0]  SPG_SHORT_COUNT  = 3'h7;
	localparam logic [2:0]  SPG_SHORT_LIMIT  = 3'h3;

	// ****************************************
	// Command byte layout
	// ****************************************
	localparam int          SPG_CMD_MEM_BIT   = 7;
	localparam int          SPG_CMD_READ_BIT  = 6;
	localparam int          SPG_CMD_FLASH_BIT = 5;

	// ****************************************
	// Memory map
	// ****************************************
	localparam logic [15:0] SPG_SAFE_BASE    = 16'h0400;
	localparam logic [15:0] SPG_SAFE_BYTES   = 16'h0010;
	localparam int          SPG_PAGE_SHIFT   = 10;
	localparam int          SPG_SEG_PINS     = 4;

	// ****************************************
	// Transaction states
	// ****************************************
	typedef enum logic [2:0] {
		SPG_IDLE  = 3'b000,
		SPG_CMD   = 3'b001,
		SPG_ADRH  = 3'b010,
		SPG_ADRL  = 3'b011,
		SPG_DATA  = 3'b100
	} spg_state_t;

endpackage : spg_pkg

/* design/spg_port.sv */
/*
 * Serial slave port with flash guard: takes command, address and
 * data bytes from an external master, reaches memory, keeps the
 * transaction status and guards flash against outside access.
 * Assumes a processor register bus on mclk, a one-cycle memory
 * port, and a master that stops its clock at least eight mclk
 * cycles between bytes.
 */
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// (RULE1) Enable bit routes the port to four shared pins whose map bits are zero; the code routes all four only while all four map bits are zero.
// (RULE2) Each received command byte is readable by the processor as a register.
// (RULE3) Restricted mode keeps only command and sixteen-byte RAM window writes.
// (RULE4) Status byte is updated at frame end and holds through the next frame.
// (RULE5) Bit seven flags a read or write that could not be performed.
// (RULE6) Bit six is parity of data bytes returned, status byte excluded.
// (RULE7) Bit five is parity of all bytes written, command and address included.
// (RULE8) Bits four to two hold the low three bits of the data byte count.
// (RULE9) Frames of one to three bytes report 111 as the count.
// (RULE10) Bit one shows flash mode and is zero while the test pin is low.
// (RULE11) Bit zero shows flash ready; master waits on it before writing.
// (RULE12) Security bit refuses flash reads from the serial or debug port.
// (RULE13) Security bit blocks erase of page zero and of engine code pages.
// (RULE14) Master sends command, then address, then data, with select held.
module spg_port
	import spg_pkg::*;
(
	// System
	input  wire logic        mclk,
	input  wire logic        rst,
	// Processor register bus
	input  wire logic        regSfr,
	input  wire logic [15:0] regAddr,
	input  wire logic        regWr,
	input  wire logic [7:0]  regWdata,
	output logic      [7:0]  regRdata,
	// Link pins
	input  wire logic        spiClk,
	input  wire logic        spiCsN,
	input  wire logic        spiMosi,
	output logic             spiMiso,
	output logic             spiMisoOe,
	// Shared pin routing
	input  wire logic [3:0]  segmentPinMap,
	output logic      [3:0]  sharedSegmentPin,
	// Memory port
	output logic      [15:0] memAddr,
	output logic      [7:0]  memWdata,
	output logic             memWe,
	output logic             memRe,
	output logic             memFlash,
	input  wire logic [7:0]  memRdata,
	input  wire logic        memReady,
	// Flash control
	input  wire logic        testPin,
	input  wire logic        flashReady,
	input  wire logic [5:0]  engineCodeLocation,
	input  wire logic [15:0] eraseAddr,
	output logic             eraseAllow,
	output logic             debugReadAllow
);
	import spg_pkg::*;

	function automatic logic regHit(input logic sfr, input logic [15:0] a,
		input logic wantSfr, input logic [15:0] want);
		regHit = (sfr == wantSfr) && (a == want);
	endfunction : regHit
	// ****************************************
	// Registers and state
	// ****************************************
	logic             flash_security_bit_q, enable_q, restrict_q, routed_q, readPend_q, flashMode_q;
	logic             isMem_q, isRead_q, isFlash_q, rdyErr_q, rdPar_q, wrPar_q;
	logic             tglSeen_q, csSeen_q, rxToggle, rxStrobe, frameStart, frameEnd;
	logic             frameIdle, writeOk, linkMiso;
	logic [1:0]       csSync_q, tglSync_q, testSync_q;
	logic [2:0]       dataCnt_q, totCnt_q;
	logic [3:0]       route_q;
	logic [7:0]       cmd_q, stat_q, tx_q, rxByte;
	logic [15:0]      addr_q;
	spg_state_t       state_q;

	// ****************************************
	// Link engine
	// ****************************************
	// Map bits are static; the gate only holds the engine idle
	assign frameIdle = spiCsN | ~routed_q;

	spg_link_shift uLink (
		.spiClk    (spiClk),
		.frameIdle (frameIdle),
		.rst       (rst),
		.mosi      (spiMosi),
		.miso      (linkMiso),
		.txByte    (tx_q),
		.rxByte    (rxByte),
		.rxToggle  (rxToggle)
	);
	assign spiMiso   = linkMiso;
	assign spiMisoOe = ~frameIdle;
	// Crossings into mclk
	always_ff @(posedge mclk) begin
		if (rst) begin
			csSync_q   <= 2'h3;
			csSeen_q   <= 1'b1;
			tglSync_q  <= 2'h0;
			tglSeen_q  <= 1'b0;
			testSync_q <= 2'h0;
		end else begin
			csSync_q   <= {csSync_q[0], frameIdle};
			csSeen_q   <= csSync_q[1];
			tglSync_q  <= {tglSync_q[0], rxToggle};
			tglSeen_q  <= tglSync_q[1];
			testSync_q <= {testSync_q[0], testPin};
		end
	end

	assign rxStrobe   = tglSync_q[1] ^ tglSeen_q;
	assign frameStart = csSeen_q & ~csSync_q[1];
	assign frameEnd   = ~csSeen_q & csSync_q[1];

	// ****************************************
	// Shared pin routing
	// ****************************************
	genvar gi;
	generate
		for (gi = 0; gi < SPG_SEG_PINS; gi++) begin : gRoute
			always_ff @(posedge mclk) begin
				if (rst) begin
					route_q[gi] <= 1'b0;
				end else begin
					// (RULE1) Pin hand-over
					route_q[gi] <= enable_q & ~|segmentPinMap;
				end
			end
		end
	endgenerate
	assign sharedSegmentPin = route_q;
	always_ff @(posedge mclk) begin
		if (rst) begin
			routed_q <= 1'b0;
		end else begin
			// (RULE1) All four pins needed
			routed_q <= &route_q;
		end
	end

	// ****************************************
	// Processor registers
	// ****************************************
	always_ff @(posedge mclk) begin
		if (rst) begin
			flash_security_bit_q   <= SPG_FLASH_SECURITY_BIT_RST;
			enable_q   <= SPG_ENABLE_RST;
			restrict_q <= SPG_RESTRICT_RST;
		end else if (regWr) begin
			if (regHit(regSfr, regAddr, 1'b1, SPG_FLASH_SECURITY_BIT_ADDR)) begin
				flash_security_bit_q <= regWdata[SPG_FLASH_SECURITY_BIT_BIT];
			end
			if (regHit(regSfr, regAddr, 1'b0, SPG_CTRL_ADDR)) begin
				enable_q   <= regWdata[SPG_ENABLE_BIT];
				restrict_q <= regWdata[SPG_RESTRICT_BIT];
			end
		end
	end

	// Unmapped locations read as zero
	always_ff @(posedge mclk) begin
		if (rst) begin
			regRdata <= 8'h00;
		end else if (regHit(regSfr, regAddr, 1'b1, SPG_FLASH_SECURITY_BIT_ADDR)) begin
			regRdata <= {1'b0, flash_security_bit_q, 6'h00};
		end else if (regHit(regSfr, regAddr, 1'b1, SPG_CMD_ADDR)) begin
			// (RULE2) Command readback
			regRdata <= cmd_q;
		end else if (regHit(regSfr, regAddr, 1'b0, SPG_STAT_ADDR)) begin
			// (RULE10) Test pin gates mode
			regRdata <= {stat_q[7:2], stat_q[1] & testSync_q[1], stat_q[0]};
		end else if (regHit(regSfr, regAddr, 1'b0, SPG_CTRL_ADDR)) begin
			regRdata <= {3'h0, enable_q, restrict_q, 3'h0};
		end else begin
			regRdata <= 8'h00;
		end
	end
	// Flash guard
	always_ff @(posedge mclk) begin
		if (rst) begin
			eraseAllow     <= 1'b0;
			debugReadAllow <= 1'b0;
		end else begin
			// (RULE13) Erase lockout
			eraseAllow <= ~(flash_security_bit_q &&
				(eraseAddr[15:SPG_PAGE_SHIFT] == 6'h00 ||
				 eraseAddr[15:SPG_PAGE_SHIFT] >= engineCodeLocation));
			// (RULE12) Debug port reads
			debugReadAllow <= ~flash_security_bit_q;
		end
	end

	// ****************************************
	// Transaction sequencing
	// ****************************************
	always_ff @(posedge mclk) begin
		if (rst) begin
			state_q <= SPG_IDLE;
		end else if (frameEnd) begin
			state_q <= SPG_IDLE;
		end else begin
			case (state_q)
				SPG_IDLE: if (frameStart) state_q <= SPG_CMD;
				// (RULE14) Command then address
				SPG_CMD: if (rxStrobe) state_q <= rxByte[SPG_CMD_MEM_BIT] ? SPG_ADRH : SPG_DATA;
				SPG_ADRH: if (rxStrobe) state_q <= SPG_ADRL;
				SPG_ADRL: if (rxStrobe) state_q <= SPG_DATA;
				SPG_DATA: state_q <= SPG_DATA;
				default: state_q <= SPG_IDLE;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			cmd_q     <= SPG_CMD_RST;
			isMem_q   <= 1'b0;
			isRead_q  <= 1'b0;
			isFlash_q <= 1'b0;
		end else if (rxStrobe && state_q == SPG_CMD) begin
			// (RULE2) Command capture, allowed even when restricted
			cmd_q     <= rxByte;
			isMem_q   <= rxByte[SPG_CMD_MEM_BIT];
			isRead_q  <= rxByte[SPG_CMD_READ_BIT];
			isFlash_q <= rxByte[SPG_CMD_FLASH_BIT];
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			addr_q <= 16'h0000;
		end else if (rxStrobe) begin
			if (state_q == SPG_ADRH) begin
				addr_q <= {rxByte, addr_q[7:0]};
			end else if (state_q == SPG_ADRL) begin
				addr_q <= {addr_q[15:8], rxByte};
			end else if (state_q == SPG_DATA && isMem_q) begin
				addr_q <= addr_q + 16'h0001;
			end
		end
	end

	// (RULE3) Restricted write window
	assign writeOk = !restrict_q ||
		(!isFlash_q && addr_q >= SPG_SAFE_BASE &&
		 addr_q < SPG_SAFE_BASE + SPG_SAFE_BYTES);

	// ****************************************
	// Memory access
	// ****************************************
	// Reads are fetched one byte ahead, so the inter-byte gap covers them
	always_ff @(posedge mclk) begin
		if (rst) begin
			memAddr    <= 16'h0000;
			memWdata   <= 8'h00;
			memWe      <= 1'b0;
			memRe      <= 1'b0;
			memFlash   <= 1'b0;
			readPend_q <= 1'b0;
		end else begin
			memWe      <= 1'b0;
			memRe      <= 1'b0;
			readPend_q <= memRe;
			if (rxStrobe && isMem_q && !isRead_q && state_q == SPG_DATA &&
			    writeOk && memReady) begin
				memAddr  <= addr_q;
				memWdata <= rxByte;
				memFlash <= isFlash_q;
				memWe    <= 1'b1;
			end else if (rxStrobe && isMem_q && isRead_q &&
			             (state_q == SPG_ADRL || state_q == SPG_DATA) &&
			             memReady && !(isFlash_q && flash_security_bit_q)) begin
				memAddr  <= (state_q == SPG_ADRL) ? {addr_q[15:8], rxByte}
				                                  : addr_q + 16'h0001;
				memFlash <= isFlash_q;
				memRe    <= 1'b1;
			end
		end
	end

	// ****************************************
	// Status accumulation
	// ****************************************
	always_ff @(posedge mclk) begin
		if (rst || frameStart) begin
			rdyErr_q    <= 1'b0;
			rdPar_q     <= 1'b0;
			wrPar_q     <= 1'b0;
			dataCnt_q   <= 3'h0;
			totCnt_q    <= 3'h0;
			flashMode_q <= 1'b0;
		end else if (rxStrobe) begin
			// (RULE7) Every written byte
			wrPar_q <= wrPar_q ^ (^rxByte);
			if (totCnt_q <= SPG_SHORT_LIMIT) begin
				totCnt_q <= totCnt_q + 3'h1;
			end
			if (state_q == SPG_DATA) begin
				// (RULE8) Data bytes only
				dataCnt_q <= dataCnt_q + 3'h1;
				if (isRead_q) begin
					// (RULE6) Byte just returned
					rdPar_q <= rdPar_q ^ (^tx_q);
				end
			end
			if (isFlash_q && isMem_q && !isRead_q) begin
				flashMode_q <= testSync_q[1];
			end
			// (RULE5) Not ready or refused
			if ((state_q == SPG_DATA && isMem_q && !isRead_q &&
			     (!memReady || !writeOk)) ||
			    (isMem_q && isRead_q &&
			     (state_q == SPG_ADRL || state_q == SPG_DATA) &&
			     (!memReady || (isFlash_q && flash_security_bit_q)))) begin
				rdyErr_q <= 1'b1;
			end
		end
	end

	// ****************************************
	// Returned byte and status
	// ****************************************
	always_ff @(posedge mclk) begin
		if (rst) begin
			tx_q <= SPG_STAT_RST;
		end else if (readPend_q) begin
			tx_q <= memRdata;
		end else if (rxStrobe && isRead_q && isMem_q &&
		             (state_q == SPG_ADRL || state_q == SPG_DATA)) begin
			// (RULE12) Refused flash read returns zero
			tx_q <= 8'h00;
		end else if (frameEnd) begin
			// Next frame opens with the fresh status
			tx_q <= {rdyErr_q, rdPar_q, wrPar_q,
				(totCnt_q <= SPG_SHORT_LIMIT) ? SPG_SHORT_COUNT : dataCnt_q,
				flashMode_q & testSync_q[1],
				flashMode_q & testSync_q[1] & flashReady};
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			stat_q <= SPG_STAT_RST;
		end else if (frameEnd && state_q != SPG_IDLE) begin
			// (RULE4) Update at frame end
			stat_q <= {rdyErr_q, rdPar_q, wrPar_q,
				// (RULE9) Short frames
				(totCnt_q <= SPG_SHORT_LIMIT) ? SPG_SHORT_COUNT : dataCnt_q,
				// (RULE10) Gated by test pin
				flashMode_q & testSync_q[1],
				// (RULE11) Flash ready
				flashMode_q & testSync_q[1] & flashReady};
		end
	end

endmodule : spg_port
`default_nettype wire

/* verif/spg_master_model.sv */
/* Serial bus master model: mode 0, most significant bit first.
   Assumes the bench calls frame() and reads rxQ afterwards. */
`timescale 1ns/1ps
`default_nettype none
module spg_master_model (
	// Link
	output logic      spiClk,
	output logic      spiCsN,
	output logic      spiMosi,
	input  wire logic spiMiso
);
	logic [7:0] rxQ [$];

	initial begin
		spiClk = 1'b0;
		spiCsN = 1'b1;
		spiMosi = 1'b0;
	end

	// command, address, data under one select
	task automatic frame(input logic [7:0] tx [$]);
		logic [7:0] b;
		rxQ.delete();
		spiCsN = 1'b0;
		#100;
		foreach (tx[i]) begin
			for (int k = 7; k >= 0; k--) begin
				spiMosi = tx[i][k];
				#7.5 spiClk = 1'b1;
				b[k] = spiMiso;
				#7.5 spiClk = 1'b0;
			end
			rxQ.push_back(b);
			// Clock stands still between bytes so the port can move the byte across
			#200;
		end
		spiCsN = 1'b1;
		spiMosi = ~spiMosi;
		#200;
	endtask : frame
endmodule : spg_master_model
`default_nettype wire

/* verif/spg_port_bench.sv */
/* Self-checking bench for spg_port with master model and memory.
   Assumes the checker binds itself from its own file. */
`timescale 1ns/1ps
`default_nettype none
module spg_port_bench;
	import spg_pkg::*;
	logic        mclk, rst, regSfr, regWr, memWe, memRe, memFlash, memReady;
	logic        spiClk, spiCsN, spiMosi, spiMiso, spiMisoOe, misoLine;
	logic        testPin, flashReady, eraseAllow, debugReadAllow, rdSample, rdHit;
	logic [7:0]  rdLow;
	logic [3:0]  segmentPinMap, sharedSegmentPin;
	logic [5:0]  engineCodeLocation, pg;
	logic [7:0]  regWdata, regRdata, memWdata, memRdata, d, prevStat;
	logic [15:0] regAddr, memAddr, eraseAddr;
	logic [7:0]  tx [$];
	logic [23:0] expMem [$];
	logic [23:0] expReg [$];
	string       rdName;
	int          nErrors = 0;
	int          checks = 0;

	spg_port spg_port_inst (.mclk, .rst, .regSfr, .regAddr, .regWr, .regWdata, .regRdata,
		.spiClk, .spiCsN, .spiMosi, .spiMiso, .spiMisoOe, .segmentPinMap, .sharedSegmentPin,
		.memAddr, .memWdata, .memWe, .memRe, .memFlash, .memRdata, .memReady, .testPin,
		.flashReady, .engineCodeLocation, .eraseAddr, .eraseAllow, .debugReadAllow);
	spg_master_model spg_master_model_inst (.spiClk, .spiCsN, .spiMosi, .spiMiso(misoLine));
	// Pulled-up line: the master sees high once the port lets go
	assign misoLine = spiMisoOe ? spiMiso : 1'b1;

	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	// Read data stands only in the cycle after the read strobe
	always @(negedge mclk) begin
		memRdata <= rdHit ? rdLow ^ 8'h5A : ~memRdata;
		rdHit    <= (memRe === 1'b1);
		rdLow    <= memAddr[7:0];
	end

	always @(posedge mclk) begin
		if (memWe === 1'b1)
			compare("memWrite", expMem.size() != 0 ? expMem.pop_front() : 24'hXXXXXX,
				{memAddr, memWdata});
		if (rdSample)
			compare(rdName, expReg.pop_front(), {16'h0000, regRdata});
	end

	task automatic compare(input string nm, input logic [23:0] e, input logic [23:0] g);
		checks++;
		if (g !== e) begin
			nErrors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : compare

	task automatic regWrite(input logic sfr, input logic [15:0] a, input logic [7:0] v);
		@(negedge mclk);
		regSfr = sfr;
		regAddr = a;
		regWdata = v;
		regWr = 1'b1;
		@(negedge mclk);
		regWr = 1'b0;
	endtask : regWrite

	task automatic regRead(input logic sfr, input logic [15:0] a, input logic [7:0] e);
		@(negedge mclk);
		regSfr = sfr;
		regAddr = a;
		expReg.push_back({16'h0000, e});
		rdName = $sformatf("reg %h", a);
		@(negedge mclk);
		rdSample = 1'b1;
		@(negedge mclk);
		rdSample = 1'b0;
	endtask : regRead

	// Sends tx, then reads back the status it should have left
	task automatic run(input logic e, input logic rp, input int n, input logic fm, input logic fr);
		logic wp;
		wp = 1'b0;
		foreach (tx[i]) wp ^= ^tx[i];
		spg_master_model_inst.frame(tx);
		prevStat = {e, rp, wp, (n < 0) ? 3'h7 : 3'(n), fm, fr};
		regRead(1'b0, SPG_STAT_ADDR, prevStat);
	endtask : run

	task automatic conclude();
		if (expMem.size() != 0 || expReg.size() != 0) begin
			nErrors++;
			$display("[ERR] pending expected 0 seen %0d", expMem.size() + expReg.size());
		end
		$display("errors %0d checks %0d", nErrors, checks);
		if (nErrors == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : conclude

	initial begin
		#300000;
		nErrors++;
		$display("[ERR] watchdog expected finish seen hang");
		conclude();
	end

	initial begin
		rst = 1'b1;
		regSfr = 1'b0;
		regAddr = 16'h0000;
		regWr = 1'b0;
		regWdata = 8'h00;
		rdSample = 1'b0;
		segmentPinMap = 4'h0;
		memRdata = 8'h00;
		rdHit = 1'b0;
		memReady = 1'b1;
		testPin = 1'b0;
		flashReady = 1'b1;
		engineCodeLocation = 6'h06;
		eraseAddr = 16'h0000;
		void'($urandom(32'hA057AAD7));
		repeat (3) @(negedge mclk);
		rst = 1'b0;
		repeat (3) @(negedge mclk);
		regRead(1'b0, SPG_STAT_ADDR, SPG_STAT_RST);
		regRead(1'b0, SPG_CTRL_ADDR, 8'h10);
		regRead(1'b0, 16'h1234, 8'h00);
		compare("pins", 4'hF, sharedSegmentPin);
		compare("debugRead", 1'b1, debugReadAllow);
		$display("test reset done");
		d = 8'($urandom);
		tx = '{8'h80, 8'h04, 8'h00, d};
		expMem.push_back({16'h0400, d});
		run(1'b0, 1'b0, 1, 1'b0, 1'b0);
		regRead(1'b1, SPG_CMD_ADDR, 8'h80);
		tx = '{8'hC0, 8'h04, 8'h00, 8'($urandom), 8'($urandom)};
		d = prevStat;
		run(1'b0, ^(8'h5A ^ 8'h5B), 2, 1'b0, 1'b0);
		compare("status byte", d, spg_master_model_inst.rxQ[0]);
		compare("read 0", 8'h5A, spg_master_model_inst.rxQ[3]);
		compare("read 1", 8'h5B, spg_master_model_inst.rxQ[4]);
		for (int n = 1; n <= 3; n++) begin
			tx = '{8'h80, 8'h04, 8'h00};
			tx = tx[0:n-1];
			run(1'b0, 1'b0, -1, 1'b0, 1'b0);
		end
		$display("test transfers done");
		regWrite(1'b0, SPG_CTRL_ADDR, 8'h18);
		tx = '{8'h80, 8'h04, 8'h10, d};
		run(1'b1, 1'b0, 1, 1'b0, 1'b0);
		tx = '{8'h80, 8'h04, 8'h0F, d};
		expMem.push_back({16'h040F, d});
		run(1'b0, 1'b0, 1, 1'b0, 1'b0);
		regWrite(1'b0, SPG_CTRL_ADDR, 8'h10);
		memReady = 1'b0;
		tx = '{8'h80, 8'h04, 8'h01, d};
		run(1'b1, 1'b0, 1, 1'b0, 1'b0);
		memReady = 1'b1;
		$display("test refusals done");
		regWrite(1'b1, SPG_FLASH_SECURITY_BIT_ADDR, 8'h40);
		for (int i = 0; i < 4; i++) begin
			pg = 6'(i * 3);
			eraseAddr = {pg, 10'($urandom)};
			@(negedge mclk);
			@(negedge mclk);
			compare("erase", !(pg == 6'h00 || pg >= engineCodeLocation), eraseAllow);
		end
		compare("debugRead", 1'b0, debugReadAllow);
		tx = '{8'hE0, 8'h04, 8'h00, d};
		run(1'b1, 1'b0, 1, 1'b0, 1'b0);
		compare("flash read", 8'h00, spg_master_model_inst.rxQ[3]);
		regWrite(1'b1, SPG_FLASH_SECURITY_BIT_ADDR, 8'h00);
		$display("test security done");
		testPin = 1'b1;
		tx = '{8'hA0, 8'h04, 8'h00, d};
		expMem.push_back({16'h0400, d});
		run(1'b0, 1'b0, 1, 1'b1, 1'b1);
		flashReady = 1'b0;
		expMem.push_back({16'h0400, d});
		run(1'b0, 1'b0, 1, 1'b1, 1'b0);
		flashReady = 1'b1;
		testPin = 1'b0;
		tx = '{8'h01};
		run(1'b0, 1'b0, -1, 1'b0, 1'b0);
		regWrite(1'b0, SPG_CTRL_ADDR, 8'h00);
		@(negedge mclk);
		compare("pins off", 4'h0, sharedSegmentPin);
		regWrite(1'b0, SPG_CTRL_ADDR, 8'h10);
		segmentPinMap = 4'h2;
		repeat (2) @(negedge mclk);
		compare("pins mapped", 4'h0, sharedSegmentPin);
		segmentPinMap = 4'h0;
		$display("test flash and pins done");
		conclude();
	end
endmodule : spg_port_bench
`default_nettype wire

/* verif/spg_port_chk.sv */
/* Port checker for spg_port.
   Assumes it is bound to spg_port and sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
module spg_port_chk
	import spg_pkg::*;
(
	// System
	input wire logic        mclk,
	input wire logic        rst,
	// Registers
	input wire logic        regSfr,
	input wire logic [15:0] regAddr,
	input wire logic        regWr,
	input wire logic [7:0]  regWdata,
	input wire logic [7:0]  regRdata,
	// Pins
	input wire logic        spiCsN,
	input wire logic        spiMisoOe,
	input wire logic [3:0]  segmentPinMap,
	input wire logic [3:0]  sharedSegmentPin,
	// Memory and flash
	input wire logic        memWe,
	input wire logic        memRe,
	input wire logic        testPin,
	input wire logic [5:0]  engineCodeLocation,
	input wire logic [15:0] eraseAddr,
	input wire logic        eraseAllow,
	input wire logic        debugReadAllow
);
	logic       secQ;
	logic       enQ;
	logic       statRd;
	logic       mapped;
	logic [5:0] page;

	// Shadows of the control bits that pins and guards depend on
	always_ff @(posedge mclk)
		if (rst)
			secQ <= SPG_FLASH_SECURITY_BIT_RST;
		else if (regWr && regSfr && regAddr == SPG_FLASH_SECURITY_BIT_ADDR)
			secQ <= regWdata[SPG_FLASH_SECURITY_BIT_BIT];
	always_ff @(posedge mclk)
		if (rst)
			enQ <= SPG_ENABLE_RST;
		else if (regWr && !regSfr && regAddr == SPG_CTRL_ADDR)
			enQ <= regWdata[SPG_ENABLE_BIT];

	assign page = eraseAddr[15:10];
	assign statRd = !regSfr && regAddr == SPG_STAT_ADDR;
	assign mapped = regSfr ? (regAddr == SPG_FLASH_SECURITY_BIT_ADDR || regAddr == SPG_CMD_ADDR)
		: (statRd || regAddr == SPG_CTRL_ADDR);

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	sequence sOut;
		!$past(rst);
	endsequence
	// Covers the pin synchroniser and the status register behind it
	sequence sTestLow;
		!testPin && !$past(testPin) && !$past(testPin, 2) && !$past(testPin, 3) && !$past(testPin, 4);
	endsequence

	a_erase_guard: assert property (sOut |->
		eraseAllow == !($past(secQ) && ($past(page) == 6'h00 || $past(page) >= $past(engineCodeLocation))))
		else $error("erase permission wrong");
	a_debug_read: assert property (sOut |-> debugReadAllow == !$past(secQ))
		else $error("debug read permission wrong");
	a_pin_route: assert property (sOut |->
		sharedSegmentPin == (($past(enQ) && $past(segmentPinMap) == 4'h0) ? 4'hF : 4'h0))
		else $error("shared pin routing wrong");
	a_drive_select: assert property (spiMisoOe |-> !spiCsN)
		else $error("data line driven while deselected");
	a_write_pulse: assert property (memWe |=> !memWe)
		else $error("write strobe longer than one cycle");
	a_read_pulse: assert property (memRe |=> !memRe && !memWe)
		else $error("read strobe longer than one cycle");
	a_unmapped_zero: assert property (sOut ##0 !$past(mapped) |-> regRdata == 8'h00)
		else $error("unmapped read not zero");
	a_flash_mode_low: assert property (sTestLow ##0 $past(statRd) |-> !regRdata[1])
		else $error("flash mode shown with test pin low");
endmodule : spg_port_chk

bind spg_port spg_port_chk spg_port_chk_inst (.mclk, .rst, .regSfr, .regAddr, .regWr,
	.regWdata, .regRdata, .spiCsN, .spiMisoOe, .segmentPinMap, .sharedSegmentPin, .memWe,
	.memRe, .testPin, .engineCodeLocation, .eraseAddr, .eraseAllow, .debugReadAllow);
`default_nettype wire
